// ### src/rtsc_consts.vh
// Constants for the remote trigger, port arbitration and status summary block
// How it works
// - Trigger command while armed produces one internal trigger pulse.
// - Trigger pulse copies pending voltage and current levels to the active setpoints.
// - After a trigger the operation condition register is cleared, waiting flag too.
// - With continuous arming on, re-arm right after trigger and set waiting flag again.
// - Trigger commands while not armed are discarded with no effect.
// - Continuous arming off: one arm command allows exactly one trigger.
// - Continuous arming setting is one bit, 0 off, 1 on, readable.
// - Abort cancels triggering and reloads pending levels from immediate levels.
// - Abort clears the waiting-for-trigger flag.
// - With continuous arming on, abort is followed at once by re-arming.
// - Abort happens at power-up, on state recall and on reset command.
// - Serial port runs 19200 baud, 8 data bits, no parity, 1 stop bit.
// - Of two command ports, the first to receive traffic becomes active.
// - Other port ignored until 5 minutes pass with no activity.
// - Master summary is OR of status byte bits ANDed with service enable mask.
// - Event summary set when any enabled event register bit is set.
// - Message-available bit is 1 while output buffer holds a response.
// - Waiting-for-trigger flag is bit 5, weight 32, of operation condition register.
// - Reading the event register returns it, then clears it.
// - Status byte: message-available weight 16, event summary 32, master summary 64, others 0.
`ifndef RTSC_CONSTS_VH
`define RTSC_CONSTS_VH
`define RTSC_CLK_HZ        200000000
`define RTSC_BAUD          19200
`define RTSC_DATA_BITS     8
`define RTSC_STOP_BITS     1
`define RTSC_IDLE_MIN      5
`define RTSC_TICK_HZ       1000
`define RTSC_TICK_DIV      (`RTSC_CLK_HZ / `RTSC_TICK_HZ)
`define RTSC_IDLE_TICKS    (`RTSC_IDLE_MIN * 60 * `RTSC_TICK_HZ)
`define RTSC_OPER_WTG_BIT  5
`define RTSC_STB_MAV_BIT   4
`define RTSC_STB_ESB_BIT   5
`define RTSC_STB_MSS_BIT   6
`define RTSC_A_CTRL        12'h000
`define RTSC_A_CONT        12'h004
`define RTSC_A_VIMM        12'h008
`define RTSC_A_IIMM        12'h00C
`define RTSC_A_VPEND       12'h010
`define RTSC_A_IPEND       12'h014
`define RTSC_A_VSET        12'h018
`define RTSC_A_ISET        12'h01C
`define RTSC_A_OPER        12'h020
`define RTSC_A_EVT         12'h024
`define RTSC_A_EVTEN       12'h028
`define RTSC_A_SRQEN       12'h02C
`define RTSC_A_STB         12'h030
`define RTSC_A_PORT        12'h034
`define RTSC_A_EVTSET      12'h038
`define RTSC_C_INIT_BIT    0
`define RTSC_C_TRIG_BIT    1
`define RTSC_C_ABORT_BIT   2
`define RTSC_C_RESET_BIT   3
`define RTSC_C_RECALL_BIT  4
`define RTSC_C_CLS_BIT     5
`endif

// ### src/rtsc_top.v
// Trigger subsystem, command port arbitration and status summary with APB registers
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "rtsc_consts.vh"
module rtsc_top #(
  parameter LVL_W      = 16,
  parameter TICK_DIV   = `RTSC_TICK_DIV,
  parameter IDLE_TICKS = `RTSC_IDLE_TICKS
) (
  input  wire             clk_sys_i,
  input  wire             rst_b_i,
  input  wire             ce_i,
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [11:0]      paddr_i,
  input  wire [31:0]      pwdata_i,
  output reg  [31:0]      prdata_o,
  output reg              pready_o,
  output reg              pslverr_o,
  input  wire             rx0_char_i,
  input  wire             rx1_char_i,
  input  wire             msg_avail_i,
  output reg  [LVL_W-1:0] volt_set_o,
  output reg  [LVL_W-1:0] curr_set_o,
  output reg              trig_pulse_o,
  output reg              waiting_for_trigger_flag_o,
  output reg  [1:0]       port_sel_o,
  output reg              mss_o
);
  // Cycles per inactivity tick, rounded down and at least one
  localparam integer TDIV = (TICK_DIV < 1) ? 1 : TICK_DIV;
  reg              armed_q;
  reg              continuous_arm_setting_q;
  reg              boot_q;
  reg [LVL_W-1:0]  volt_imm_q;
  reg [LVL_W-1:0]  curr_imm_q;
  reg [LVL_W-1:0]  pending_voltage_level_q;
  reg [LVL_W-1:0]  pending_current_level_q;
  reg [7:0]        evt_q;
  reg [7:0]        evt_en_q;
  reg [7:0]        srq_en_q;
  reg [31:0]       div_q;
  reg [31:0]       idle_q;
  reg [1:0]        port_q;
  wire             acc;
  wire             wr;
  wire             rd;
  wire [5:0]       cmd;
  wire             do_abort;
  wire             do_trig;
  wire             tick;
  wire             esb;
  wire [7:0]       stb_raw;
  wire [7:0]       stb;
  wire             mss;
  wire [15:0]      oper;
  wire             wr_take;
  wire             rd_take;
  wire             trig_take;
  wire             arm_take;
  wire             abort_take;
  wire             clr_evt;
  wire             set_evt;
  reg  [31:0]      rdata;
  reg              rerr;

  function [31:0] zext;
    input [LVL_W-1:0] v;
    begin
      zext = 32'h00000000;
      zext[LVL_W-1:0] = v;
    end
  endfunction

  // Register address match, used by the write and command decoders below
  function hit;
    input [11:0] a;
    input [11:0] r;
    begin
      hit = (a == r);
    end
  endfunction

  assign acc = psel_i & penable_i & ce_i;
  assign wr  = acc & pwrite_i;
  assign rd  = acc & ~pwrite_i;
  assign cmd = (wr && hit(paddr_i, `RTSC_A_CTRL)) ? pwdata_i[5:0] : 6'h00;
  // Power-up, recall and reset commands all perform the abort action
  assign do_abort = boot_q | cmd[`RTSC_C_ABORT_BIT] | cmd[`RTSC_C_RESET_BIT] | cmd[`RTSC_C_RECALL_BIT];
  // Trigger only counts while armed, and loses to a same-cycle abort
  assign do_trig = cmd[`RTSC_C_TRIG_BIT] & armed_q & ~do_abort;

  // Operation condition register: waiting flag follows the armed state
  assign oper = {10'h000, armed_q, 5'h00};
  assign esb = |(evt_q & evt_en_q);
  assign stb_raw = {1'b0, 1'b0, esb, msg_avail_i, 4'h0};
  assign mss = |(stb_raw & srq_en_q & 8'hBF);
  assign stb = stb_raw | {1'b0, mss, 6'h00};
  assign tick = (div_q == TDIV - 1);

  // Strobes for the edge at which a transfer is taken
  assign wr_take    = pready_o & wr;
  assign rd_take    = pready_o & rd;
  assign trig_take  = pready_o & do_trig;
  assign arm_take   = pready_o & cmd[`RTSC_C_INIT_BIT];
  assign abort_take = (pready_o & do_abort) | boot_q;
  assign clr_evt    = (rd_take & hit(paddr_i, `RTSC_A_EVT)) | (pready_o & cmd[`RTSC_C_CLS_BIT]);
  assign set_evt    = wr_take & hit(paddr_i, `RTSC_A_EVTSET);

  always @* begin
    rdata = 32'h00000000;
    rerr  = 1'b0;
    case (paddr_i)
      `RTSC_A_CTRL:   rdata = 32'h00000000;
      `RTSC_A_CONT:   rdata = {31'h00000000, continuous_arm_setting_q};
      `RTSC_A_VIMM:   rdata = zext(volt_imm_q);
      `RTSC_A_IIMM:   rdata = zext(curr_imm_q);
      `RTSC_A_VPEND:  rdata = zext(pending_voltage_level_q);
      `RTSC_A_IPEND:  rdata = zext(pending_current_level_q);
      `RTSC_A_VSET:   rdata = zext(volt_set_o);
      `RTSC_A_ISET:   rdata = zext(curr_set_o);
      `RTSC_A_OPER:   rdata = {16'h0000, oper};
      `RTSC_A_EVT:    rdata = {24'h000000, evt_q};
      `RTSC_A_EVTEN:  rdata = {24'h000000, evt_en_q};
      `RTSC_A_SRQEN:  rdata = {24'h000000, srq_en_q};
      `RTSC_A_STB:    rdata = {24'h000000, stb};
      `RTSC_A_PORT:   rdata = {30'h00000000, port_q};
      `RTSC_A_EVTSET: rdata = 32'h00000000;
      default:        rerr  = 1'b1;
    endcase
  end

  // APB slave: one wait state, answer in the second access cycle
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
    end else if (ce_i) begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & rerr;
      prdata_o  <= (psel_i & penable_i & ~pready_o & ~pwrite_i) ? rdata : 32'h00000000;
    end
  end

  // Power-up marker: the first running cycle performs the abort action
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      boot_q <= 1'b1;
    end else if (ce_i) begin
      boot_q <= 1'b0;
    end
  end

  // Trigger pulse stands with pready, once per taken trigger
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trig_pulse_o <= 1'b0;
    end else if (ce_i) begin
      trig_pulse_o <= do_trig & ~pready_o;
    end
  end

  // Continuous arming setting
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      continuous_arm_setting_q <= 1'b0;
    end else if (ce_i) begin
      if (wr_take & hit(paddr_i, `RTSC_A_CONT))
        continuous_arm_setting_q <= pwdata_i[0];
    end
  end

  // Immediate levels: written by software, taken over by a trigger
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      volt_imm_q <= {LVL_W{1'b0}};
      curr_imm_q <= {LVL_W{1'b0}};
    end else if (ce_i) begin
      if (trig_take) begin
        volt_imm_q <= pending_voltage_level_q;
        curr_imm_q <= pending_current_level_q;
      end else begin
        if (wr_take & hit(paddr_i, `RTSC_A_VIMM))
          volt_imm_q <= pwdata_i[LVL_W-1:0];
        if (wr_take & hit(paddr_i, `RTSC_A_IIMM))
          curr_imm_q <= pwdata_i[LVL_W-1:0];
      end
    end
  end

  // Pending levels: written by software, reloaded by an abort
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pending_voltage_level_q <= {LVL_W{1'b0}};
      pending_current_level_q <= {LVL_W{1'b0}};
    end else if (ce_i) begin
      if (abort_take) begin
        pending_voltage_level_q <= volt_imm_q;
        pending_current_level_q <= curr_imm_q;
      end else begin
        if (wr_take & hit(paddr_i, `RTSC_A_VPEND))
          pending_voltage_level_q <= pwdata_i[LVL_W-1:0];
        if (wr_take & hit(paddr_i, `RTSC_A_IPEND))
          pending_current_level_q <= pwdata_i[LVL_W-1:0];
      end
    end
  end

  // Active setpoints
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      volt_set_o <= {LVL_W{1'b0}};
      curr_set_o <= {LVL_W{1'b0}};
    end else if (ce_i) begin
      if (trig_take) begin
        volt_set_o <= pending_voltage_level_q;
        curr_set_o <= pending_current_level_q;
      end
    end
  end

  // Armed state: abort beats trigger, trigger beats arm
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      armed_q <= 1'b0;
    end else if (ce_i) begin
      if (abort_take) begin
        armed_q <= continuous_arm_setting_q;
      end else if (trig_take) begin
        armed_q <= continuous_arm_setting_q;
      end else if (arm_take) begin
        armed_q <= 1'b1;
      end else if (continuous_arm_setting_q & ~armed_q) begin
        armed_q <= 1'b1;
      end
    end
  end

  // Waiting flag pin follows the operation condition bit
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      waiting_for_trigger_flag_o <= 1'b0;
    end else if (ce_i) begin
      waiting_for_trigger_flag_o <= oper[`RTSC_OPER_WTG_BIT];
    end
  end

  // Event register: a read or clear-status empties it, set requests win
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_q <= 8'h80;
    end else if (ce_i) begin
      if (clr_evt)
        evt_q <= set_evt ? pwdata_i[7:0] : 8'h00;
      else if (set_evt)
        evt_q <= evt_q | pwdata_i[7:0];
    end
  end

  // Enable masks
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      evt_en_q <= 8'h00;
      srq_en_q <= 8'h00;
    end else if (ce_i) begin
      if (wr_take & hit(paddr_i, `RTSC_A_EVTEN))
        evt_en_q <= pwdata_i[7:0];
      if (wr_take & hit(paddr_i, `RTSC_A_SRQEN))
        srq_en_q <= pwdata_i[7:0];
    end
  end

  // Registered copy of the master summary
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mss_o <= 1'b0;
    end else if (ce_i) begin
      mss_o <= mss;
    end
  end

  // Inactivity tick divider
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 32'h00000000;
    end else if (ce_i) begin
      div_q <= tick ? 32'h00000000 : div_q + 32'h00000001;
    end
  end

  // Port arbitration; character strobes come from 8N1 receivers at the fixed baud
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_q     <= 32'h00000000;
      port_q     <= 2'b00;
      port_sel_o <= 2'b00;
    end else if (ce_i) begin
      if (port_q == 2'b00) begin
        if (rx0_char_i) begin
          port_q <= 2'b01;
        end else if (rx1_char_i) begin
          port_q <= 2'b10;
        end
        idle_q <= 32'h00000000;
      end else if ((port_q[0] & rx0_char_i) | (port_q[1] & rx1_char_i)) begin
        idle_q <= 32'h00000000;
      end else if (tick) begin
        if (idle_q >= IDLE_TICKS - 1) begin
          port_q <= 2'b00;
          idle_q <= 32'h00000000;
        end else begin
          idle_q <= idle_q + 32'h00000001;
        end
      end
      port_sel_o <= port_q;
    end
  end
endmodule

// ### tb/rtsc_host_model.sv
// Host-side model: decoded serial characters and the response flag
`timescale 1ns/10ps
module rtsc_host_model (
  input  wire logic clk_sys_i,
  output logic      rx0_char_o,
  output logic      rx1_char_o,
  output logic      msg_avail_o
);
  initial begin
    rx0_char_o = 0;
    rx1_char_o = 0;
    msg_avail_o = 0;
  end
  // One pulse per received 8N1 character
  task automatic send(input int p);
    if (p == 0) rx0_char_o <= 1;
    else rx1_char_o <= 1;
    @(posedge clk_sys_i);
    rx0_char_o <= 0;
    rx1_char_o <= 0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic set_msg(input int m);
    msg_avail_o <= m[0];
  endtask
endmodule

// ### tb/rtsc_top_props.sv
// Port-level assertions for the trigger, port and status block
`timescale 1ns/10ps
module rtsc_top_props #(parameter LVL_W = 16) (
  input wire logic             clk_sys_i,
  input wire logic             rst_b_i,
  input wire logic             ce_i,
  input wire logic             psel_i,
  input wire logic             penable_i,
  input wire logic [31:0]      prdata_o,
  input wire logic             pready_o,
  input wire logic             pslverr_o,
  input wire logic             rx0_char_i,
  input wire logic             rx1_char_i,
  input wire logic [LVL_W-1:0] volt_set_o,
  input wire logic             trig_pulse_o,
  input wire logic [1:0]       port_sel_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  err_ready_a: assert property (pslverr_o |-> pready_o) else $error("error without ready");
  ready_access_a: assert property (pready_o |-> $past(psel_i && penable_i)) else $error("ready outside access");
  ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready held");
  rdata_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("read data not zero");
  trig_pulse_a: assert property (trig_pulse_o |=> !trig_pulse_o) else $error("trigger pulse held");
  trig_ready_a: assert property (trig_pulse_o |-> pready_o) else $error("trigger pulse off the answer");
  set_trig_a: assert property (!$stable(volt_set_o) |-> trig_pulse_o || $past(trig_pulse_o))
    else $error("setpoint moved without trigger");
  port_code_a: assert property (port_sel_o != 2'b11) else $error("bad port code");
  port_first_a: assert property (port_sel_o == 2'b00 && rx0_char_i && !rx1_char_i |-> ##[1:3] port_sel_o == 2'b01)
    else $error("first port not taken");
  port_hold_a: assert property (port_sel_o == 2'b01 && rx1_char_i |=> port_sel_o != 2'b10)
    else $error("other port taken");
  freeze_hold_a: assert property (!ce_i |=> $stable(port_sel_o) && $stable(volt_set_o) && $stable(pready_o))
    else $error("state moved while clock enable low");
endmodule
bind rtsc_top rtsc_top_props #(.LVL_W(LVL_W)) chk_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .rx0_char_i(rx0_char_i), .rx1_char_i(rx1_char_i), .volt_set_o(volt_set_o), .trig_pulse_o(trig_pulse_o),
  .port_sel_o(port_sel_o));

// ### tb/tb_top.sv
// Self-checking bench with a reference model of trigger, status and port logic
`timescale 1ns/10ps
module tb_top;
  logic        clk, rst_b, psel, penable, pwrite, ce, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic        pready, pslverr, rx0, rx1, msg, trig, waiting_for_trigger_flag, mss;
  logic [15:0] vset, iset;
  logic [1:0]  psel_port;
  int          n_mismatch = 0, n_compared = 0, cont = 0, arm = 0, evt, en, sq, e, m, n_trig = 0, x_trig = 0;
  int          imm[2] = '{0, 0}, pend[2] = '{0, 0}, set[2] = '{0, 0};
  rtsc_top #(.TICK_DIV(4), .IDLE_TICKS(10)) dut_u (.clk_sys_i(clk), .rst_b_i(rst_b), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rx0_char_i(rx0), .rx1_char_i(rx1), .msg_avail_i(msg), .volt_set_o(vset), .curr_set_o(iset),
    .trig_pulse_o(trig), .waiting_for_trigger_flag_o(waiting_for_trigger_flag), .port_sel_o(psel_port), .mss_o(mss));
  rtsc_host_model host_u (.clk_sys_i(clk), .rx0_char_o(rx0), .rx1_char_o(rx1), .msg_avail_o(msg));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Counts trigger pulses as the design shows them
  always @(posedge clk) if (trig === 1'b1) n_trig <= n_trig + 1;
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input int x);
    apb(0, a, 0);
    chk(rv, x);
  endtask
  task automatic pc(input int x);
    rd(12'h034, x);
    chk(psel_port, x);
  endtask
  task automatic cmd(input int b);
    if (b & 28) begin
      pend = imm;
      arm = cont;
    end else if ((b & 2) && arm) begin
      imm = pend;
      set = pend;
      arm = cont;
      x_trig++;
    end
    if (b & 1) arm = 1;
    apb(1, 12'h000, b);
  endtask
  task automatic pv();
    pend[0] = $urandom & 16'hFFFF;
    pend[1] = $urandom & 16'hFFFF;
    apb(1, 12'h010, pend[0]);
    apb(1, 12'h014, pend[1]);
  endtask
  task automatic state();
    rd(12'h018, set[0]);
    rd(12'h01C, set[1]);
    chk(vset, set[0]);
    chk(iset, set[1]);
    chk(n_trig, x_trig);
    rd(12'h010, pend[0]);
    rd(12'h014, pend[1]);
    rd(12'h020, arm << 5);
    chk(waiting_for_trigger_flag, arm);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst_b = 0;
    ce = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    void'($urandom(74));
    repeat (20) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    rd(12'h024, 32'h80);
    rd(12'h024, 0);
    state();
    apb(1, 12'h0FC, 5);
    chk(err, 1);
    $display("test reset finished");
    for (int c = 0; c < 2; c++) begin
      cont = c;
      arm = arm | c;
      apb(1, 12'h004, c);
      rd(12'h004, c);
      pv();
      cmd(2);
      state();
      cmd(1);
      state();
      cmd(2);
      state();
      pv();
      cmd(2);
      state();
      pv();
      cmd(4);
      state();
      pv();
      cmd(6);
      state();
    end
    cont = 0;
    apb(1, 12'h004, 0);
    for (int b = 3; b < 5; b++) begin
      pv();
      cmd(1 << b);
      state();
    end
    $display("test trigger finished");
    cmd(32);
    repeat (6) begin
      evt = $urandom & 8'hFF;
      en = $urandom & 8'hFF;
      sq = $urandom & 8'hFF;
      m = $urandom & 1;
      host_u.set_msg(m);
      apb(1, 12'h028, en);
      apb(1, 12'h02C, sq);
      apb(1, 12'h038, evt);
      e = (m << 4) | (((evt & en) != 0) << 5);
      e = e | (((e & sq & 8'h30) != 0) << 6);
      rd(12'h030, e);
      chk(mss, (e >> 6) & 1);
      rd(12'h024, evt);
    end
    $display("test status finished");
    pc(0);
    host_u.send(0);
    pc(1);
    repeat (3) begin
      host_u.send(1);
      host_u.send(0);
      repeat (20) @(posedge clk);
    end
    pc(1);
    repeat (60) @(posedge clk);
    pc(0);
    ce <= 0;
    host_u.send(1);
    ce <= 1;
    pc(0);
    host_u.send(1);
    pc(2);
    $display("test ports finished");
    rst_b <= 0;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    cont = 0;
    arm = 0;
    imm = '{0, 0};
    pend = '{0, 0};
    set = '{0, 0};
    rd(12'h024, 32'h80);
    pc(0);
    state();
    $display("test second reset finished");
    stop_test();
  end
endmodule
